// ---- hw/dmit_pkg.sv ----
package dmit_pkg;

  // System clock period and basic clock periods, in ns.
  localparam int ClkPeriodNs = 25;
  localparam int Basic100kNs = 10000;
  localparam int Basic10kNs = 100000;
  localparam int Basic2kNs = 500000;
  localparam int Basic1kNs = 1000000;

  // Basic clock periods as system clock counts.
  localparam int Cyc100k = Basic100kNs / ClkPeriodNs;
  localparam int Cyc10k = Basic10kNs / ClkPeriodNs;
  localparam int Cyc2k = Basic2kNs / ClkPeriodNs;
  localparam int Cyc1k = Basic1kNs / ClkPeriodNs;

  // Peripheral addresses of the buffer-moved registers.
  localparam logic [7:0] AddrChan1Match = 8'h1c;
  localparam logic [7:0] AddrChan1Count = 8'h1d;
  localparam logic [7:0] AddrChan2Match = 8'h1e;
  localparam logic [7:0] AddrChan2Count = 8'h1f;

  // Register file addresses of the 4-bit control registers.
  localparam logic [7:0] AddrChan2Control = 8'h29;
  localparam logic [7:0] AddrChan1Control = 8'h2a;

  // Control register field positions.
  localparam int RunBit = 3;
  localparam int ClearBit = 2;
  localparam int SelLsb = 0;

  // Reset values.
  localparam logic [7:0] MatchReset = 8'hff;
  localparam logic [7:0] CountReset = 8'h00;
  localparam logic [3:0] ControlReset = 4'h0;

  // Basic clock choices of the select field.
  typedef enum logic [1:0] {
    DMIT_SEL_100K,
    DMIT_SEL_10K,
    DMIT_SEL_2K,
    DMIT_SEL_1K
  } dmit_sel_type;

  // Stored part of one control register.
  typedef struct packed {
    logic run;
    dmit_sel_type sel;
  } dmit_ctrl_type;

  // State of one counting channel.
  typedef struct packed {
    logic [7:0] count;
    logic run;
    logic irq;
  } dmit_chan_type;

endpackage

// ---- hw/dmit_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
// One modulo interval channel, stepped by the shared basic clock ticks.
module dmit_channel
  import dmit_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic softReset,
  input wire logic [3:0] tickVec,
  input wire dmit_ctrl_type ctrl,
  input wire logic countClear,
  input wire logic [7:0] matchValue,
  output logic [7:0] count,
  output logic irqPulse
);

  // Whole channel state and its next value.
  dmit_chan_type c_q;
  dmit_chan_type c_d;
  // Tick of the basic clock chosen by the select field.
  logic selTick;
  // Count after one more step.
  logic [7:0] stepCount;

  assign selTick = tickVec[ctrl.sel];
  assign stepCount = c_q.count + 8'h01;

  // Next state: the run flag is only sampled on a tick, which gives the
  // one-tick start and stop uncertainty but never a runt count.
  always_comb begin
    c_d = c_q;
    c_d.irq = 1'b0;
    if (softReset) begin
      c_d = '0;
    end else begin
      if (selTick) begin
        c_d.run = ctrl.run;
        if (c_q.run) begin
          if (stepCount == matchValue) begin
            c_d.count = 8'h00;
            c_d.irq = 1'b1;
          end else begin
            c_d.count = stepCount;
          end
        end
      end
      // A clear restarts from zero and waits for the next tick.
      if (countClear) begin
        c_d.count = 8'h00;
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign count = c_q.count;
  assign irqPulse = c_q.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_irq_one_cycle: assert property (irqPulse |=> !irqPulse)
    else $error("interrupt pulse longer than one cycle");
  a_irq_cause: assert property (irqPulse |-> $past(selTick && c_q.run && stepCount == matchValue && !softReset))
    else $error("interrupt without a match");
  a_match_clears: assert property (irqPulse |-> count == 8'h00)
    else $error("count not cleared on match");
  a_stopped_holds: assert property ((!c_q.run && !countClear && !softReset) |=> $stable(count))
    else $error("count moved while stopped");
  a_clear_zero: assert property ((countClear && !softReset) |=> count == 8'h00)
    else $error("clear did not zero count");
  a_soft_reset: assert property (softReset |=> count == 8'h00 && !c_q.run)
    else $error("soft reset did not clear channel");
  a_step_by_one: assert property (($changed(count) && count != 8'h00) |-> count == $past(count) + 8'h01)
    else $error("count stepped by other than one");
  a_run_on_tick: assert property ((selTick && !softReset) |=> c_q.run == $past(ctrl.run))
    else $error("run flag not taken on tick");

endmodule
`default_nettype wire

// ---- hw/dmit_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two modulo interval timers behind the control register file and the
// transfer buffer. The block makes its own basic clock ticks from ref_clk.
module dmit_top
  import dmit_pkg::*;
#(
  parameter int Cyc10kP = Cyc10k,
  parameter int Cyc2kP = Cyc2k,
  parameter int Cyc1kP = Cyc1k
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic watchdog_stack_reset,
  input wire logic clockStop,
  input wire logic ceReset,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [3:0] regWdata,
  output logic [3:0] regRdata,
  input wire logic [7:0] bufAddr,
  input wire logic buffer_store_instr,
  input wire logic buffer_load_instr,
  input wire logic [15:0] transfer_buffer,
  output logic [15:0] bufRdata,
  output logic [1:0] irqPulse
);

  // Cascade ratios between successive basic clocks.
  localparam int Ratio10k = Cyc10kP / Cyc100k;
  localparam int Ratio2k = Cyc2kP / Cyc10kP;
  localparam int Ratio1k = Cyc1kP / Cyc2kP;

  // All state of the top level in one record.
  typedef struct packed {
    logic [15:0] pre100k;
    logic [7:0] pre10k;
    logic [7:0] pre2k;
    logic [7:0] pre1k;
    dmit_ctrl_type [1:0] ctrl;
    logic [1:0][7:0] match;
    logic [3:0] regRdata;
    logic [15:0] bufRdata;
  } dmit_top_type;

  dmit_top_type s_q;
  dmit_top_type s_d;

  // Basic clock ticks, one system cycle wide, 100k up to 1k.
  logic [3:0] tickVec;
  // Power-on-like resets that arrive synchronously. A CE reset is not
  // among them: every timer keeps its state and keeps counting.
  logic softReset;
  // Per channel clear strobes and counts.
  logic [1:0] clearStrobe;
  logic [1:0][7:0] chanCount;
  // Channel addresses, indexed by channel.
  logic [1:0][7:0] ctrlAddr;
  logic [1:0][7:0] matchAddr;
  logic [1:0][7:0] countAddr;

  assign softReset = watchdog_stack_reset | clockStop;
  assign ctrlAddr = {AddrChan2Control, AddrChan1Control};
  assign matchAddr = {AddrChan2Match, AddrChan1Match};
  assign countAddr = {AddrChan2Count, AddrChan1Count};

  // The slower ticks only fire together with the faster one, so all four
  // stay phase aligned and a select change costs at most one new period.
  assign tickVec[0] = (s_q.pre100k == 16'(Cyc100k - 1));
  assign tickVec[1] = tickVec[0] && (s_q.pre10k == 8'(Ratio10k - 1));
  assign tickVec[2] = tickVec[1] && (s_q.pre2k == 8'(Ratio2k - 1));
  assign tickVec[3] = tickVec[2] && (s_q.pre1k == 8'(Ratio1k - 1));

  // Clear strobes come from control writes with bit 2 set. The bit is
  // never stored, so it reads back as zero.
  generate
    for (genvar i = 0; i < 2; i++) begin : gChan
      assign clearStrobe[i] = regWrite && !softReset && regAddr == ctrlAddr[i]
                              && regWdata[ClearBit];
      dmit_channel uChan (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .softReset(softReset),
        .tickVec(tickVec),
        .ctrl(s_q.ctrl[i]),
        .countClear(clearStrobe[i]),
        .matchValue(s_q.match[i]),
        .count(chanCount[i]),
        .irqPulse(irqPulse[i])
      );
    end
  endgenerate

  // Next state of prescaler, registers and read data.
  always_comb begin
    s_d = s_q;
    // Prescaler runs free; watchdog/stack reset and clock stop do not disturb it.
    if (tickVec[0]) begin
      s_d.pre100k = 16'h0000;
      s_d.pre10k = tickVec[1] ? 8'h00 : s_q.pre10k + 8'h01;
    end else begin
      s_d.pre100k = s_q.pre100k + 16'h0001;
    end
    if (tickVec[1]) begin
      s_d.pre2k = tickVec[2] ? 8'h00 : s_q.pre2k + 8'h01;
    end
    if (tickVec[2]) begin
      s_d.pre1k = tickVec[3] ? 8'h00 : s_q.pre1k + 8'h01;
    end
    if (softReset) begin
      // Watchdog/stack reset and clock stop act like power-on.
      for (int i = 0; i < 2; i++) begin
        s_d.ctrl[i] = dmit_ctrl_type'(3'(ControlReset));
        s_d.match[i] = MatchReset;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (regWrite && regAddr == ctrlAddr[i]) begin
          s_d.ctrl[i].run = regWdata[RunBit];
          s_d.ctrl[i].sel = dmit_sel_type'(regWdata[SelLsb +: 2]);
        end
        // Only the low byte is taken; a zero load is the caller's fault.
        if (buffer_store_instr && bufAddr == matchAddr[i]) begin
          s_d.match[i] = transfer_buffer[7:0];
        end
        // Stores to a count address are dropped.
      end
    end
    // Read data stands until the next read of the same port.
    if (regRead) begin
      s_d.regRdata = 4'h0;
      for (int i = 0; i < 2; i++) begin
        if (regAddr == ctrlAddr[i]) begin
          s_d.regRdata = {s_q.ctrl[i].run, 1'b0, s_q.ctrl[i].sel};
        end
      end
    end
    if (buffer_load_instr) begin
      s_d.bufRdata = 16'h0000;
      for (int i = 0; i < 2; i++) begin
        if (bufAddr == matchAddr[i]) begin
          s_d.bufRdata = {8'h00, s_q.match[i]};
        end
        if (bufAddr == countAddr[i]) begin
          s_d.bufRdata = {8'h00, chanCount[i]};
        end
      end
    end
  end

  // State register; power-on values only.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.pre100k <= 16'h0000;
      s_q.pre10k <= 8'h00;
      s_q.pre2k <= 8'h00;
      s_q.pre1k <= 8'h00;
      s_q.ctrl <= '0;
      s_q.match <= {MatchReset, MatchReset};
      s_q.regRdata <= 4'h0;
      s_q.bufRdata <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.regRdata;
  assign bufRdata = s_q.bufRdata;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_clear_reads_zero: assert property (regRdata[ClearBit] == 1'b0)
    else $error("clear bit read as one");
  a_match_reset: assert property (softReset |=> s_q.match[0] == MatchReset && s_q.match[1] == MatchReset)
    else $error("match not reloaded with ones");
  a_ce_keeps_ctrl: assert property ((ceReset && !softReset && !regWrite) |=> $stable(s_q.ctrl))
    else $error("control changed on CE reset");
  a_count_read: assert property ((buffer_load_instr && bufAddr == AddrChan1Count)
                                 |=> bufRdata == {8'h00, $past(chanCount[0])})
    else $error("count read mismatch");
  a_tick_spacing: assert property (tickVec[0] |=> !tickVec[0] [*8])
    else $error("basic ticks too close");

endmodule
`default_nettype wire

// ---- verification/dmit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the two interval channels; all stimulus goes through the ports.
module tb
  import dmit_pkg::*;
;
  logic ref_clk = 1'b0; // System clock, 40 MHz.
  logic rst_b = 1'b0; // Power-on reset, active low.
  logic watchdog_stack_reset = 1'b0, clockStop = 1'b0, ceReset = 1'b0;
  logic regWrite = 1'b0, regRead = 1'b0, buffer_store_instr = 1'b0, buffer_load_instr = 1'b0;
  logic [7:0] regAddr = 8'h00, bufAddr = 8'h00;
  logic [3:0] regWdata = 4'h0;
  logic [15:0] transfer_buffer = 16'h0000;
  logic [3:0] regRdata;
  logic [15:0] bufRdata;
  logic [1:0] irqPulse;
  int miscompares = 0, checks = 0, cycles = 0;
  logic [15:0] c1, c2; // Count snapshots, taken while channel 1 is halted and while channel 2 runs.
  int n; // Cycles between two interrupt pulses.

  dmit_top dmit_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .watchdog_stack_reset(watchdog_stack_reset),
    .clockStop(clockStop), .ceReset(ceReset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .bufAddr(bufAddr), .buffer_store_instr(buffer_store_instr),
    .buffer_load_instr(buffer_load_instr), .transfer_buffer(transfer_buffer), .bufRdata(bufRdata),
    .irqPulse(irqPulse));

  // Clock generator.
  always #12.5 ref_clk = ~ref_clk;

  // The whole run needs about 28000 cycles, so this ceiling only trips on a hang.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      summarize();
    end
  end

  // Compares one value and counts the outcome.
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Control register write; the strobe is held for exactly one edge.
  task automatic regWr(input logic [7:0] a, input logic [3:0] d);
    @(posedge ref_clk) begin
      regAddr <= a; regWdata <= d; regWrite <= 1'b1;
    end
    @(posedge ref_clk) regWrite <= 1'b0;
  endtask

  // Control register read; data is valid one cycle after the request edge.
  task automatic regChk(input string nm, input logic [7:0] a, input logic [3:0] exp);
    @(posedge ref_clk) begin
      regAddr <= a; regRead <= 1'b1;
    end
    @(posedge ref_clk) regRead <= 1'b0;
    #1 check(nm, {12'h000, regRdata}, {12'h000, exp});
  endtask

  // Buffer store of one byte into a peripheral register.
  task automatic bufWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) begin
      bufAddr <= a; transfer_buffer <= {8'h00, d}; buffer_store_instr <= 1'b1;
    end
    @(posedge ref_clk) buffer_store_instr <= 1'b0;
  endtask

  // Buffer load of one peripheral register.
  task automatic bufRd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk) begin
      bufAddr <= a; buffer_load_instr <= 1'b1;
    end
    @(posedge ref_clk) buffer_load_instr <= 1'b0;
    #1 d = bufRdata;
  endtask

  task automatic bufChk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [15:0] d;
    bufRd(a, d);
    check(nm, d, {8'h00, exp});
  endtask

  // Counts cycles until the chosen interrupt pulse shows, up to a limit.
  task automatic waitIrq(input int idx, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1 cnt++;
    end while (irqPulse[idx] !== 1'b1 && cnt < lim);
  endtask

  task automatic t_reset();
    bufChk("match1", AddrChan1Match, 8'hff);
    bufChk("match2", AddrChan2Match, 8'hff);
    bufChk("count1", AddrChan1Count, 8'h00);
    bufChk("count2", AddrChan2Count, 8'h00);
    regChk("ctrl1", AddrChan1Control, 4'h0);
    regChk("ctrl2", AddrChan2Control, 4'h0);
    regChk("unmapped", 8'h2b, 4'h0);
    $display("test reset done");
  endtask

  // Every select code is written with the clear bit set; it must read back as zero.
  task automatic t_ctrl();
    for (int s = 0; s < 4; s++) begin
      regWr(AddrChan1Control, {2'b01, s[1:0]});
      regChk("sel1", AddrChan1Control, {2'b00, s[1:0]});
    end
    regWr(AddrChan2Control, 4'hf);
    regChk("ctrl2run", AddrChan2Control, 4'hb);
    regWr(AddrChan2Control, 4'h4);
    $display("test control done");
  endtask

  // Matches recur at exactly match times the basic period; channel 1's pulse is checked to be a single cycle.
  task automatic t_interval();
    bufWr(AddrChan1Match, 8'h03);
    regWr(AddrChan1Control, 4'hc);
    waitIrq(0, 3000, n);
    check("irq1", {15'h0000, irqPulse[0]}, 16'h0001);
    waitIrq(0, 3000, n);
    check("period1", n[15:0], 16'(3 * Cyc100k));
    @(posedge ref_clk) #1 check("irq1low", {15'h0000, irqPulse[0]}, 16'h0000);
    bufChk("count1wrap", AddrChan1Count, 8'h00);
    bufWr(AddrChan2Match, 8'h02);
    regWr(AddrChan2Control, 4'hd);
    waitIrq(1, 20000, n);
    waitIrq(1, 20000, n);
    check("period2", n[15:0], 16'(2 * Cyc10k));
    $display("test interval done");
  endtask

  // A halted count holds; writing zero to clear keeps it, writing one zeroes it.
  task automatic t_runClear();
    bufWr(AddrChan1Match, 8'h20);
    regWr(AddrChan1Control, 4'hc);
    repeat (2100) @(posedge ref_clk);
    regWr(AddrChan1Control, 4'h0);
    repeat (500) @(posedge ref_clk);
    bufRd(AddrChan1Count, c1);
    check("countmoved", {15'h0000, c1 == 16'h0000}, 16'h0000);
    repeat (900) @(posedge ref_clk);
    bufRd(AddrChan1Count, c2);
    check("halted", c2, c1);
    regWr(AddrChan1Control, 4'h0);
    bufChk("noclear", AddrChan1Count, c1[7:0]);
    regWr(AddrChan1Control, 4'h4);
    bufChk("cleared", AddrChan1Count, 8'h00);
    $display("test run clear done");
  endtask

  // Stores to a count address are ignored; the match value reads back.
  task automatic t_store();
    bufWr(AddrChan1Count, 8'h77);
    bufChk("countro", AddrChan1Count, 8'h00);
    bufWr(AddrChan2Match, 8'h5a);
    bufChk("match2rw", AddrChan2Match, 8'h5a);
    $display("test store done");
  endtask

  // CE reset keeps everything and channel 2 keeps counting; watchdog and clock stop restore reset values.
  task automatic t_soft();
    bufRd(AddrChan2Count, c1);
    @(posedge ref_clk) ceReset <= 1'b1;
    @(posedge ref_clk) ceReset <= 1'b0;
    repeat (4100) @(posedge ref_clk);
    bufRd(AddrChan2Count, c2);
    check("count2ce", {15'h0000, c2 > c1}, 16'h0001);
    bufChk("match2ce", AddrChan2Match, 8'h5a);
    regChk("ctrl2ce", AddrChan2Control, 4'h9);
    @(posedge ref_clk) watchdog_stack_reset <= 1'b1;
    @(posedge ref_clk) watchdog_stack_reset <= 1'b0;
    bufChk("match2wd", AddrChan2Match, 8'hff);
    regChk("ctrl2wd", AddrChan2Control, 4'h0);
    bufChk("count2wd", AddrChan2Count, 8'h00);
    bufWr(AddrChan1Match, 8'h11);
    @(posedge ref_clk) clockStop <= 1'b1;
    @(posedge ref_clk) clockStop <= 1'b0;
    bufChk("match1cs", AddrChan1Match, 8'hff);
    $display("test soft reset done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence: reset for 20 cycles, then each scenario in turn.
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_ctrl();
    t_interval();
    t_runClear();
    t_store();
    t_soft();
    summarize();
  end
endmodule
`default_nettype wire
